// >>> src/sfpt_pkg.sv
// constants and types for the discoverable parameter table responder
// =====================================================================
// Overview of operation
// - byte 30h bits 1:0 read 01b; byte 31h reads 4 KB erase opcode 20h.
// - byte 30h bits 7:5 fixed at 111b; whole byte reads E5h.
// - byte 30h bits 3 and 4 read zero; no write enable needed.
// - dword 30h bits 18:17 read 00b, three-byte addressing only.
// - byte 32h reads F1h: no DTR, dual and quad fast reads supported.
// - byte 33h reads FFh; bytes 34h-37h hold density as bits minus one.
// - byte 38h reads 44h: four dummy clocks, mode bits 010b for quad I/O.
// - byte 39h reads EBh, the quad I/O fast read opcode.
// - byte 3Ah reads 08h: eight dummy clocks, no mode bits, quad output.
// - byte 3Bh reads 6Bh, the quad output fast read opcode.
// - zero wait-state field means unsupported; 000b mode field means no mode bits.
// - cs low, opcode 5Ah, three address bytes, one dummy, data until cs high.
// - header points to the table at 30h with length nine dwords.
package sfpt_pkg;
  // =================================================================
  // serial command
  localparam logic [7:0] CMD_PARAM_READ = 8'h5a;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  // =================================================================
  // table fields
  localparam logic [23:0] TBL_BASE = 24'h000030;
  localparam logic [7:0] TBL_PTR = 8'h30;
  localparam logic [7:0] TBL_DWORDS = 8'h09;
  localparam logic [1:0] ERASE_4K_CODE = 2'h1;
  localparam logic [2:0] FIXED_TOP = 3'h7;
  localparam logic [1:0] WREN_BITS = 2'h0;
  localparam logic WR_GRAN = 1'h1;
  localparam logic [7:0] ERASE_FLAGS = {FIXED_TOP, WREN_BITS, WR_GRAN, ERASE_4K_CODE};
  localparam logic [7:0] ERASE_4K_OP = 8'h20;
  localparam logic [3:0] QD_SUPPORT = 4'hf;
  localparam logic DTR_SUPPORT = 1'h0;
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic DUAL_OUT = 1'h1;
  localparam logic [7:0] FAST_RD_FLAGS = {QD_SUPPORT, DTR_SUPPORT, ADDR_MODE, DUAL_OUT};
  localparam logic [7:0] UNUSED_BYTE = 8'hff;
  localparam logic [4:0] QIO_WAIT = 5'h04;
  localparam logic [2:0] QIO_MODE = 3'h2;
  localparam logic [4:0] QOUT_WAIT = 5'h08;
  localparam logic [2:0] NO_MODE = 3'h0;
  localparam logic [7:0] QIO_OP = 8'heb;
  localparam logic [7:0] QOUT_OP = 8'h6b;
  localparam logic [31:0] SIGNATURE = 32'h50444653;
  localparam logic [7:0] HDR_MINOR = 8'h00;
  localparam logic [7:0] HDR_MAJOR = 8'h01;
  localparam logic [7:0] HDR_COUNT = 8'h00;
  localparam logic [7:0] HDR_JEDEC_ID = 8'h00;
  // =================================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_READS = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam int STS_UNDER_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =================================================================
  // types
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_CMD = 6'h02, ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08, ST_DATA = 6'h10, ST_SKIP = 6'h20
  } sfpt_state_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } sfpt_pins_t;
endpackage

// >>> src/sfpt_rom.sv
// serial parameter table responder with axi4-lite control and status
`timescale 1ns/1ps
module sfpt_rom import sfpt_pkg::*; #(
  parameter logic [31:0] DENSITY = 32'h01ffffff,
  parameter int DEPTH = 2,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // sized one bit wider than the pointers so that a full count of DEPTH survives
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  // =================================================================
  // table contents; bytes outside header and table read as ff
  function automatic logic [7:0] tbl_byte(input logic [23:0] a);
    logic [7:0] b;
    b = UNUSED_BYTE;
    if (a[23:8] == 16'h0000) begin
      unique case (a[7:0])
        8'h00: b = SIGNATURE[7:0];
        8'h01: b = SIGNATURE[15:8];
        8'h02: b = SIGNATURE[23:16];
        8'h03: b = SIGNATURE[31:24];
        8'h04: b = HDR_MINOR;
        8'h05: b = HDR_MAJOR;
        8'h06: b = HDR_COUNT;
        8'h08: b = HDR_JEDEC_ID;
        8'h09: b = HDR_MINOR;
        8'h0a: b = HDR_MAJOR;
        8'h0b: b = TBL_DWORDS;
        8'h0c: b = TBL_PTR;
        8'h0d: b = 8'h00;
        8'h0e: b = 8'h00;
        8'h30: b = ERASE_FLAGS;
        8'h31: b = ERASE_4K_OP;
        8'h32: b = FAST_RD_FLAGS;
        8'h34: b = DENSITY[7:0];
        8'h35: b = DENSITY[15:8];
        8'h36: b = DENSITY[23:16];
        8'h37: b = DENSITY[31:24];
        8'h38: b = {QIO_MODE, QIO_WAIT};
        8'h39: b = QIO_OP;
        8'h3a: b = {NO_MODE, QOUT_WAIT};
        8'h3b: b = QOUT_OP;
        default: b = UNUSED_BYTE;
      endcase
    end
    return b;
  endfunction

  // register decode shared by both bus channels
  function automatic logic reg_hit(input logic [AW-1:0] a);
    return a[AW-1:4] == '0 && a[1:0] == 2'h0;
  endfunction

  // =================================================================
  // pin synchronisers; the edge detector reads only stages two and three
  sfpt_pins_t pin_s1;
  sfpt_pins_t pin_s2;
  sfpt_pins_t pin_s3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 3'h2;
      pin_s2 <= 3'h2;
      pin_s3 <= 3'h2;
    end else if (ce) begin
      pin_s1 <= '{sclk: sclk, cs_n: cs_n, si: si};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  logic rise;
  logic fall;
  assign rise = pin_s2.sclk & ~pin_s3.sclk;
  assign fall = ~pin_s2.sclk & pin_s3.sclk;

  // =================================================================
  // command decode
  sfpt_state_t state;
  sfpt_state_t next_state;
  logic ctrl_en;
  logic [7:0] in_sh;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic byte_done;
  logic [7:0] in_byte;
  assign byte_done = rise && bit_cnt == 3'h7;
  assign in_byte = {in_sh[6:0], pin_s2.si};

  always_comb begin
    next_state = state;
    if (pin_s2.cs_n) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: next_state = ctrl_en ? ST_CMD : ST_SKIP;
        ST_CMD: begin
          if (byte_done) begin
            next_state = (in_byte == CMD_PARAM_READ) ? ST_ADDR : ST_SKIP;
          end
        end
        ST_ADDR: begin
          if (byte_done && byte_cnt == ADDR_BYTES - 2'h1) begin
            next_state = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (byte_done) begin
            next_state = ST_DATA;
          end
        end
        ST_DATA: next_state = ST_DATA;
        ST_SKIP: next_state = ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // input shifter, counting bits and bytes of the header phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sh <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (ce) begin
      if (state == ST_IDLE) begin
        bit_cnt <= 3'h0;
        byte_cnt <= 2'h0;
      end else if (rise) begin
        in_sh <= in_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_done && state == ST_ADDR) begin
          byte_cnt <= byte_cnt + 2'h1;
        end
      end
    end
  end

  // =================================================================
  // table fetch into the two-entry buffer; stalls while it is full
  logic [23:0] rd_addr;
  logic push;
  logic pop;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] push_byte;
  assign push_byte = tbl_byte(rd_addr);
  assign push = buf_in_ready && (state == ST_DUMMY || state == ST_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr <= 24'h000000;
    end else if (ce) begin
      if (state == ST_ADDR && byte_done) begin
        rd_addr <= {rd_addr[15:0], in_byte};
      end else if (push) begin
        rd_addr <= rd_addr + 24'h000001;
      end
    end
  end

  logic [7:0] buf_mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] buf_cnt;
  assign buf_in_ready = buf_cnt != FULL_CNT;
  assign buf_out_valid = buf_cnt != '0;

  always_ff @(posedge aclk) begin
    if (ce && push) begin
      buf_mem[wr_ptr] <= push_byte;
    end
  end

  // a dropped chip select flushes whatever was fetched ahead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      buf_cnt <= '0;
    end else if (ce) begin
      if (state == ST_IDLE) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        buf_cnt <= '0;
      end else begin
        if (push) begin
          wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
          buf_cnt <= buf_cnt + 1'b1;
        end else if (pop && !push) begin
          buf_cnt <= buf_cnt - 1'b1;
        end
      end
    end
  end

  // =================================================================
  // output serializer: msb first, changes on the falling serial edge
  logic [7:0] out_sh;
  logic [2:0] out_cnt;
  logic underrun;
  logic load_byte;
  assign load_byte = state == ST_DATA && fall && out_cnt == 3'h0;
  assign pop = load_byte && buf_out_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so <= 1'b1;
      so_oe <= 1'b0;
      out_sh <= 8'h00;
      out_cnt <= 3'h0;
    end else if (ce) begin
      so_oe <= next_state == ST_DATA;
      if (state != ST_DATA) begin
        // line idles high so a new frame never starts from a stale data bit
        so <= 1'b1;
        out_cnt <= 3'h0;
      end else if (load_byte) begin
        // an empty buffer only happens if sclk outruns the fetch; send ones then
        so <= buf_out_valid ? buf_mem[rd_ptr][7] : 1'b1;
        out_sh <= buf_out_valid ? {buf_mem[rd_ptr][6:0], 1'b0} : 8'hfe;
        out_cnt <= 3'h7;
      end else if (fall) begin
        so <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
        out_cnt <= out_cnt - 3'h1;
      end
    end
  end

  // =================================================================
  // axi4-lite slave
  logic aw_held;
  logic w_held;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic clr_under;
  logic [15:0] reads;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign clr_under = do_write && reg_hit(aw_addr) && aw_addr[3:0] == REG_STATUS[3:0]
    && w_strb[1] && w_data[STS_UNDER_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // the enable only matters at the next chip select, never mid-frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= CTRL_EN_RST;
    end else if (ce && do_write && reg_hit(aw_addr) && aw_addr[3:0] == REG_CTRL[3:0]
        && w_strb[0]) begin
      ctrl_en <= w_data[CTRL_EN_BIT];
    end
  end

  // sticky underrun: a new event in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underrun <= 1'b0;
      reads <= 16'h0000;
    end else if (ce) begin
      if (load_byte && !buf_out_valid) begin
        underrun <= 1'b1;
      end else if (clr_under) begin
        underrun <= 1'b0;
      end
      if (state == ST_DUMMY && next_state == ST_DATA) begin
        reads <= reads + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= 32'h00000000;
        if (reg_hit(s_axi_araddr)) begin
          unique case (s_axi_araddr[3:0])
            REG_CTRL[3:0]: s_axi_rdata[CTRL_EN_BIT] <= ctrl_en;
            REG_STATUS[3:0]: s_axi_rdata <= {23'h0, underrun, 2'h0, state};
            REG_READS[3:0]: s_axi_rdata <= {16'h0000, reads};
            REG_ADDR[3:0]: s_axi_rdata <= {8'h00, rd_addr};
            default: s_axi_rdata <= 32'h00000000;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // =================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic tbl_push;
  assign tbl_push = ce && push;

  chk_erase_granule: assert property (
    tbl_push && rd_addr == TBL_BASE |-> push_byte[1:0] == ERASE_4K_CODE
      ##0 1) else $error("erase granule field wrong");
  chk_fixed_top: assert property (
    tbl_push && rd_addr == TBL_BASE |-> push_byte == ERASE_FLAGS
      && push_byte[7:5] == FIXED_TOP) else $error("byte 30h top bits wrong");
  chk_wren_clear: assert property (
    tbl_push && rd_addr == TBL_BASE |-> push_byte[4:3] == 2'h0)
    else $error("write enable bits set");
  chk_addr_mode: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'h2 |-> push_byte[2:1] == 2'h0)
    else $error("address mode not three-byte");
  chk_dtr_clear: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'h2 |-> !push_byte[3] && push_byte[0]
      && push_byte[7:4] == QD_SUPPORT) else $error("fast read flags wrong");
  chk_density_top: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'h7 |-> push_byte == DENSITY[31:24])
    else $error("density byte wrong");
  chk_qio_wait: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'h8 |-> push_byte[4:0] == QIO_WAIT
      && push_byte[7:5] == QIO_MODE) else $error("quad io wait field wrong");
  chk_qio_opcode: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'h9 |-> push_byte == QIO_OP)
    else $error("quad io opcode wrong");
  chk_qout_wait: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'ha |-> push_byte[4:0] == QOUT_WAIT
      && push_byte[7:5] == NO_MODE) else $error("quad out wait field wrong");
  chk_qout_opcode: assert property (
    tbl_push && rd_addr == TBL_BASE + 24'hb |-> push_byte == QOUT_OP)
    else $error("quad out opcode wrong");
  chk_header_ptr: assert property (
    tbl_push && rd_addr == 24'h00000c |-> push_byte == TBL_PTR)
    else $error("table pointer wrong");
  chk_addr_step: assert property (
    tbl_push |=> rd_addr == $past(rd_addr) + 24'h000001)
    else $error("address did not step by one");

  sequence s_last_addr_byte;
    ce && !pin_s2.cs_n && state == ST_ADDR && byte_done
      && byte_cnt == ADDR_BYTES - 2'h1;
  endsequence
  sequence s_dummy_then_data;
    state == ST_DUMMY ##[1:1000] (ce && byte_done) ##1 state == ST_DATA;
  endsequence
  chk_hdr_to_dummy: assert property (
    s_last_addr_byte |=> state == ST_DUMMY) else $error("no dummy phase");
  chk_cs_abort: assert property (
    ce && pin_s2.cs_n && state != ST_IDLE |=> state == ST_IDLE ##1 !so_oe)
    else $error("chip select release not honoured");
  chk_data_drive: assert property (
    s_dummy_then_data |-> so_oe) else $error("output not driven in data");
endmodule // sfpt_rom

// >>> verif/sfpt_host_model.sv
// serial host model that issues parameter table reads over the four-wire link
`timescale 1ns/1ps
module sfpt_host_model (
  input wire logic aclk,
  input wire logic so,
  input wire logic so_oe,
  output logic sclk,
  output logic cs_n,
  output logic si
);
  // half period of 6 aclk keeps sclk below the synchroniser limit with margin
  localparam int HALF = 6;
  logic [7:0] rx[$];
  logic oe_all;
  logic oe_any;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic put_bit(input logic b);
    si <= b;
    tick(HALF);
    sclk <= 1'b1;
    tick(HALF);
    sclk <= 1'b0;
  endtask
  // =====================================================================
  // framed read
  // extra bits beyond the whole bytes end the frame in mid-byte
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int n, input int extra);
    logic [31:0] hdr;
    logic [7:0] b;
    hdr = {op, a};
    b = 8'h00;
    rx.delete();
    oe_all = 1'b1;
    oe_any = 1'b0;
    cs_n <= 1'b0;
    tick(4);
    for (int i = 31; i >= 0; i--) put_bit(hdr[i]);
    for (int i = 0; i < 8; i++) put_bit(1'b0);
    for (int k = 0; k < n * 8 + extra; k++) begin
      tick(HALF);
      b = {b[6:0], so};
      oe_all &= so_oe;
      oe_any |= so_oe;
      sclk <= 1'b1;
      tick(HALF);
      sclk <= 1'b0;
      if (k % 8 == 7) rx.push_back(b);
    end
    tick(HALF);
    cs_n <= 1'b1;
    // released line must not keep its last value
    si <= ~si;
    tick(8);
  endtask
endmodule // sfpt_host_model

// >>> verif/sfpt_rom_tb_top.sv
// self-checking bench for the parameter table responder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module sfpt_rom_tb_top import sfpt_pkg::*;;
  localparam logic [31:0] DEN = 32'h01ffffff;
  logic aclk, aresetn, ce, so, so_oe, sclk, cs_n, si;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [23:0] a;
  int n_errors, tests_run, cycles, n_reads;

  sfpt_rom #(.DENSITY(DEN), .DEPTH(2), .AW(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sfpt_host_model host (.aclk(aclk), .so(so), .so_oe(so_oe), .sclk(sclk), .cs_n(cs_n), .si(si));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end
  // =====================================================================
  // reference table
  function automatic logic [7:0] ref_byte(input int ad);
    logic [7:0] hdr[16];
    logic [7:0] v;
    hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
            8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};
    v = 8'hff;
    if (ad < 16) v = hdr[ad];
    case (ad)
      'h30: v = 8'he5;
      'h31: v = 8'h20;
      'h32: v = 8'hf1;
      'h34: v = DEN[7:0];
      'h35: v = DEN[15:8];
      'h36: v = DEN[23:16];
      'h37: v = DEN[31:24];
      'h38: v = 8'h44;
      'h39: v = 8'heb;
      'h3a: v = 8'h08;
      'h3b: v = 8'h6b;
      default: ;
    endcase
    return v;
  endfunction
  // =====================================================================
  // bus and compare tasks
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= ad;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rs);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic check_rx(input int ad);
    `CHK("oe in data", 1'b1, host.oe_all)
    `CHK("oe after cs", 1'b0, so_oe)
    foreach (host.rx[i]) `CHK("table byte", ref_byte(ad + i), host.rx[i])
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // =====================================================================
  // main sequence
  initial begin
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
    ce = 1'b1;
    d = $urandom(26);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl reset", 32'h1, d)
    axi_rd(REG_STATUS, d, r);
    `CHK("idle state", 6'h01, d[5:0])
    host.xfer(CMD_PARAM_READ, 24'h000030, 12, 0);
    n_reads++;
    check_rx('h30);
    `CHK("erase code", 2'b01, host.rx[0][1:0])
    `CHK("fixed top", 3'b111, host.rx[0][7:5])
    `CHK("wren bits", 2'b00, host.rx[0][4:3])
    `CHK("addr bytes", 2'b00, host.rx[2][2:1])
    `CHK("dtr bit", 1'b0, host.rx[2][3])
    `CHK("unused 33", 8'hff, host.rx[3])
    `CHK("qio wait", 5'h04, host.rx[8][4:0])
    `CHK("qio mode", 3'h2, host.rx[8][7:5])
    `CHK("qout wait", 5'h08, host.rx[10][4:0])
    `CHK("qout mode", 3'h0, host.rx[10][7:5])
    host.xfer(CMD_PARAM_READ, 24'h000000, 16, 0);
    n_reads++;
    check_rx(0);
    `CHK("table ptr", 8'h30, host.rx[12])
    `CHK("table len", 8'h09, host.rx[11])
    for (int t = 0; t < 5; t++) begin
      a = 24'($urandom_range(8'h3f, 8'h2c));
      host.xfer(CMD_PARAM_READ, a, $urandom_range(6, 1), $urandom_range(7, 0));
      n_reads++;
      check_rx(a);
    end
    host.xfer(8'h03, 24'h000030, 2, 0);
    `CHK("bad op oe", 1'b0, host.oe_any)
    `CHK("bad op idle", 8'hff, host.rx[0])
    axi_wr(REG_CTRL, 32'h0, r);
    `CHK("ctrl wr resp", RESP_OKAY, r)
    host.xfer(CMD_PARAM_READ, 24'h000030, 1, 0);
    `CHK("disabled oe", 1'b0, host.oe_any)
    axi_wr(REG_CTRL, 32'h1, r);
    host.xfer(CMD_PARAM_READ, 24'h000038, 2, 3);
    n_reads++;
    check_rx('h38);
    axi_rd(REG_READS, d, r);
    `CHK("read count", n_reads[15:0], d[15:0])
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(REG_READS, d, r);
    `CHK("reads after reset", 32'h0, d)
    host.xfer(CMD_PARAM_READ, 24'h000031, 2, 0);
    check_rx('h31);
    axi_wr(8'h10, 32'h0, r);
    `CHK("unmapped wr", RESP_SLVERR, r)
    axi_rd(8'h20, d, r);
    `CHK("unmapped rd", RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    axi_rd(8'h06, d, r);
    `CHK("misaligned rd", RESP_SLVERR, r)
    axi_rd(REG_CTRL, d, r);
    `CHK("ctrl kept", 32'h1, d)
    axi_rd(REG_STATUS, d, r);
    `CHK("final state", 6'h01, d[5:0])
    `CHK("no underrun", 1'b0, d[STS_UNDER_BIT])
    results();
  end
endmodule // sfpt_rom_tb_top
